// File: verilog/pdr_pkg.sv
// constants and register map for the port data register block
package pdr_pkg;
    // ==========================================================
    // register offsets (plain port, word addresses)
    localparam logic [3:0]  ADDR_WIDTH      = 4'h4;
    localparam logic [3:0]  OFS_PORTD_UPPER = 4'h0;
    localparam logic [3:0]  OFS_PORTD_LOWER = 4'h1;
    localparam logic [3:0]  OFS_PORTE_DATA  = 4'h2;
    localparam logic [3:0]  OFS_PORTF_INPUT = 4'h3;
    // ==========================================================
    // widths and reset values
    localparam int          PORTD_PINS      = 32;
    localparam int          PORTE_PINS      = 16;
    localparam int          PORTF_PINS      = 8;
    localparam int          PORTD_UPPER_LSB = 16;
    localparam logic [15:0] PORTD_RST       = 16'h0000;
    localparam logic [15:0] PORTE_RST       = 16'h0000;
    // ==========================================================
    // timing: two flip-flops on every pin input
    localparam int          SYNC_STAGES     = 2;
endpackage : pdr_pkg

// File: verilog/pdr_sync.sv
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module pdr_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,   // system clock
    input  wire logic             nrst_i,  // async reset, low
    input  wire logic [WIDTH-1:0] d_i,     // asynchronous pins
    output logic      [WIDTH-1:0] q_o      // synchronised levels
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } pdr_sync_state_t;

    pdr_sync_state_t st_reg;
    pdr_sync_state_t st_next;

    // ==========================================================
    // first stage feeds only the second stage
    always_comb begin
        st_next      = st_reg;
        st_next.meta = d_i;
        st_next.sync = st_reg.meta;
    end

    // state register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q_o = st_reg.sync;
endmodule : pdr_sync

// File: verilog/pdr_ports.sv
// data registers of ports d, e and f with pin read-back
//
// Function
// [R1] port d dir 0: read pin, write stores only
// [R2] port d dir 1: read stored, drive if general fn
// [R3] upper register holds port d pins 31..16
// [R4] port e data: 16 bits, read/write
// [R5] port e general output: write drives pin
// [R6] port e dir 0: read pin, write stores
// [R7] port e dir 1 other function: no drive
// [R8] port f: 8-bit read-only pin register
// [R9] writes to port f are discarded
// [R10] port f general input reads live pin
// [R11] port f analog sampling reads as one
// [R12] port f has no fixed reset value
// [R13] port e data clears on reset
// [R14] dir/function inputs, pins synchronised first
`timescale 1ns/1ps
module pdr_ports #(
    parameter int PD_PINS = pdr_pkg::PORTD_PINS,
    parameter int PE_PINS = pdr_pkg::PORTE_PINS,
    parameter int PF_PINS = pdr_pkg::PORTF_PINS
) (
    input  wire logic               clk_i,         // 25 MHz clock
    input  wire logic               nrst_i,        // async reset, low
    input  wire logic [3:0]         addr_i,        // register address
    input  wire logic [15:0]        wdata_i,       // write data
    input  wire logic               wr_i,          // write strobe
    input  wire logic               rd_i,          // read strobe
    output logic      [15:0]        rdata_o,       // read data
    input  wire logic [PD_PINS-1:0] portd_dir_i,   // 1 = output
    input  wire logic [PD_PINS-1:0] portd_gpio_i,  // 1 = general fn
    input  wire logic [PE_PINS-1:0] porte_dir_i,   // 1 = output
    input  wire logic [PE_PINS-1:0] porte_gpio_i,  // 1 = general fn
    input  wire logic [PF_PINS-1:0] portf_adc_i,   // analog sampling
    input  wire logic [PD_PINS-1:0] portd_pin_i,   // port d pin level
    output logic      [PD_PINS-1:0] portd_pin_o,   // port d drive
    output logic      [PD_PINS-1:0] portd_oe_n_o,  // low = driving
    input  wire logic [PE_PINS-1:0] porte_pin_i,   // port e pin level
    output logic      [PE_PINS-1:0] porte_pin_o,   // port e drive
    output logic      [PE_PINS-1:0] porte_oe_n_o,  // low = driving
    input  wire logic [PF_PINS-1:0] portf_pin_i    // port f pin level
);
    localparam int UL = pdr_pkg::PORTD_UPPER_LSB;

    typedef struct packed {
        logic [PD_PINS-1:0] pd_data;
        logic [PE_PINS-1:0] pe_data;
        logic [PD_PINS-1:0] pd_out;
        logic [PD_PINS-1:0] pd_oe_n;
        logic [PE_PINS-1:0] pe_out;
        logic [PE_PINS-1:0] pe_oe_n;
        logic [15:0]        rdata;
    } pdr_state_t;

    pdr_state_t st_reg;
    pdr_state_t st_next;

    logic [PD_PINS-1:0] pd_sync;
    logic [PE_PINS-1:0] pe_sync;
    logic [PF_PINS-1:0] pf_sync;
    logic [PD_PINS-1:0] pd_view;
    logic [PE_PINS-1:0] pe_view;
    logic [PF_PINS-1:0] pf_view;
    logic [PD_PINS-1:0] pd_drive;
    logic [PE_PINS-1:0] pe_drive;

    // ==========================================================
    // pin synchronisers
    // all pins cross two flip-flops before any read path [R14]
    pdr_sync #(.WIDTH(PD_PINS)) u_sync_d (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (portd_pin_i),
        .q_o    (pd_sync)
    );
    pdr_sync #(.WIDTH(PE_PINS)) u_sync_e (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (porte_pin_i),
        .q_o    (pe_sync)
    );
    pdr_sync #(.WIDTH(PF_PINS)) u_sync_f (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (portf_pin_i),
        .q_o    (pf_sync)
    );

    // ==========================================================
    // per-pin read view and drive selection
    genvar gi;
    // port d: pin level when input, stored bit when output
    for (gi = 0; gi < PD_PINS; gi++) begin : g_pd
        assign pd_view[gi]  = portd_dir_i[gi] ? st_reg.pd_data[gi]
                                              : pd_sync[gi];   // [R1] [R2]
        assign pd_drive[gi] = portd_dir_i[gi] & portd_gpio_i[gi]; // [R2]
    end
    // port e: same table as port d
    for (gi = 0; gi < PE_PINS; gi++) begin : g_pe
        assign pe_view[gi]  = porte_dir_i[gi] ? st_reg.pe_data[gi]
                                              : pe_sync[gi];   // [R5] [R6]
        assign pe_drive[gi] = porte_dir_i[gi] & porte_gpio_i[gi]; // [R7]
    end
    // port f: live level, or one while analog sampling runs
    for (gi = 0; gi < PF_PINS; gi++) begin : g_pf
        assign pf_view[gi] = portf_adc_i[gi] | pf_sync[gi]; // [R10] [R11]
    end

    // ==========================================================
    // next state: writes, pin drive and read data
    always_comb begin
        st_next       = st_reg;
        st_next.rdata = 16'h0000;
        if (wr_i) begin
            unique case (addr_i)
                pdr_pkg::OFS_PORTD_UPPER: begin
                    st_next.pd_data[PD_PINS-1:UL] = wdata_i; // [R3]
                end
                pdr_pkg::OFS_PORTD_LOWER: begin
                    st_next.pd_data[UL-1:0] = wdata_i;       // [R3]
                end
                pdr_pkg::OFS_PORTE_DATA: begin
                    st_next.pe_data = wdata_i;               // [R4]
                end
                default: begin
                    // port f and unmapped writes are dropped [R9]
                end
            endcase
        end
        if (rd_i) begin
            unique case (addr_i)
                pdr_pkg::OFS_PORTD_UPPER: begin
                    st_next.rdata = pd_view[PD_PINS-1:UL];
                end
                pdr_pkg::OFS_PORTD_LOWER: begin
                    st_next.rdata = pd_view[UL-1:0];
                end
                pdr_pkg::OFS_PORTE_DATA: begin
                    st_next.rdata = pe_view;
                end
                pdr_pkg::OFS_PORTF_INPUT: begin
                    st_next.rdata = {8'h00, pf_view};        // [R8] [R12]
                end
                default: begin
                    st_next.rdata = 16'h0000;
                end
            endcase
        end
        // drive follows stored bit only for general outputs
        st_next.pd_out  = st_next.pd_data & pd_drive;          // [R2]
        st_next.pd_oe_n = ~pd_drive;
        st_next.pe_out  = st_next.pe_data & pe_drive;          // [R5]
        st_next.pe_oe_n = ~pe_drive;
    end

    // state register; port e clears on reset
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg         <= '0;                              // [R13]
            st_reg.pd_data <= PD_PINS'({2{pdr_pkg::PORTD_RST}});
            st_reg.pe_data <= PE_PINS'(pdr_pkg::PORTE_RST);    // [R13]
            st_reg.pd_oe_n <= '1;
            st_reg.pe_oe_n <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flip-flops
    assign rdata_o      = st_reg.rdata;
    assign portd_pin_o  = st_reg.pd_out;
    assign portd_oe_n_o = st_reg.pd_oe_n;
    assign porte_pin_o  = st_reg.pe_out;
    assign porte_oe_n_o = st_reg.pe_oe_n;

    // ==========================================================
    // assertions
    AST_PE_RESET_ZERO: assert property (@(posedge clk_i)       // [R13]
        $rose(nrst_i) |-> st_reg.pe_data == 16'h0000)
        else $error("port e data not clear after reset");

    AST_PF_WRITE_IGNORED: assert property (@(posedge clk_i)    // [R9]
        disable iff (!nrst_i)
        wr_i && addr_i == pdr_pkg::OFS_PORTF_INPUT
        |=> $stable(st_reg.pd_data) && $stable(st_reg.pe_data))
        else $error("port f write changed storage");

    AST_PE_WRITE_STORES: assert property (@(posedge clk_i)     // [R4]
        disable iff (!nrst_i)
        wr_i && addr_i == pdr_pkg::OFS_PORTE_DATA
        |=> st_reg.pe_data == $past(wdata_i))
        else $error("port e write not stored");

    AST_PD_UPPER_MAP: assert property (@(posedge clk_i)        // [R3]
        disable iff (!nrst_i)
        wr_i && addr_i == pdr_pkg::OFS_PORTD_UPPER
        |=> st_reg.pd_data[PD_PINS-1:UL] == $past(wdata_i)
            && $stable(st_reg.pd_data[UL-1:0]))
        else $error("port d upper write misplaced");

    AST_PE_DRIVE: assert property (@(posedge clk_i)            // [R5]
        disable iff (!nrst_i)
        wr_i && addr_i == pdr_pkg::OFS_PORTE_DATA
        && porte_dir_i[0] && porte_gpio_i[0]
        |=> porte_pin_o[0] == $past(wdata_i[0]) && !porte_oe_n_o[0])
        else $error("port e output bit not driven");

    AST_PE_NO_DRIVE: assert property (@(posedge clk_i)         // [R7]
        disable iff (!nrst_i)
        !(porte_dir_i[0] && porte_gpio_i[0]) |=> porte_oe_n_o[0])
        else $error("port e drives a non-output pin");

    AST_PD_READ_PIN: assert property (@(posedge clk_i)         // [R1]
        disable iff (!nrst_i)
        rd_i && addr_i == pdr_pkg::OFS_PORTD_LOWER && !portd_dir_i[0]
        |=> rdata_o[0] == $past(pd_sync[0]))
        else $error("port d input read not pin level");

    AST_PD_READ_STORED: assert property (@(posedge clk_i)      // [R2]
        disable iff (!nrst_i)
        rd_i && addr_i == pdr_pkg::OFS_PORTD_LOWER && portd_dir_i[0]
        |=> rdata_o[0] == $past(st_reg.pd_data[0]))
        else $error("port d output read not stored bit");

    AST_PE_READ_PIN: assert property (@(posedge clk_i)         // [R6]
        disable iff (!nrst_i)
        rd_i && addr_i == pdr_pkg::OFS_PORTE_DATA && !porte_dir_i[0]
        |=> rdata_o[0] == $past(pe_sync[0]))
        else $error("port e input read not pin level");

    AST_PF_ANALOG_ONE: assert property (@(posedge clk_i)       // [R11]
        disable iff (!nrst_i)
        rd_i && addr_i == pdr_pkg::OFS_PORTF_INPUT && portf_adc_i[0]
        |=> rdata_o[0] && rdata_o[15:8] == 8'h00)
        else $error("port f analog bit not read as one");

    AST_PF_LIVE_PIN: assert property (@(posedge clk_i)         // [R10]
        disable iff (!nrst_i)
        rd_i && addr_i == pdr_pkg::OFS_PORTF_INPUT && !portf_adc_i[1]
        |=> rdata_o[1] == $past(pf_sync[1]))
        else $error("port f read not live pin");

    // port d lower half, drive, pin release and upper read-back
    AST_PD_LOWER_MAP: assert property (@(posedge clk_i)        // [R3]
        disable iff (!nrst_i)
        wr_i && addr_i == pdr_pkg::OFS_PORTD_LOWER
        |=> st_reg.pd_data[UL-1:0] == $past(wdata_i)
            && $stable(st_reg.pd_data[PD_PINS-1:UL]))
        else $error("port d lower write misplaced");

    AST_PD_DRIVE: assert property (@(posedge clk_i)            // [R2]
        disable iff (!nrst_i)
        wr_i && addr_i == pdr_pkg::OFS_PORTD_LOWER
        && portd_dir_i[0] && portd_gpio_i[0]
        |=> portd_pin_o[0] == $past(wdata_i[0]) && !portd_oe_n_o[0])
        else $error("port d output bit not driven");

    AST_PD_NO_DRIVE: assert property (@(posedge clk_i)         // [R1]
        disable iff (!nrst_i)
        !portd_dir_i[0] |=> portd_oe_n_o[0] && !portd_pin_o[0])
        else $error("port d drives an input pin");

    AST_PD_UPPER_READ: assert property (@(posedge clk_i)       // [R3]
        disable iff (!nrst_i)
        rd_i && addr_i == pdr_pkg::OFS_PORTD_UPPER && portd_dir_i[UL]
        |=> rdata_o[0] == $past(st_reg.pd_data[UL]))
        else $error("port d upper read misplaced");

    // port e read-back of stored bits and release of input pins
    AST_PE_READ_DRIVEN: assert property (@(posedge clk_i)      // [R5]
        disable iff (!nrst_i)
        rd_i && addr_i == pdr_pkg::OFS_PORTE_DATA
        && porte_dir_i[0] && porte_gpio_i[0]
        |=> rdata_o[0] == $past(st_reg.pe_data[0]))
        else $error("port e output read not stored bit");

    AST_PE_READ_OTHER: assert property (@(posedge clk_i)       // [R7]
        disable iff (!nrst_i)
        rd_i && addr_i == pdr_pkg::OFS_PORTE_DATA
        && porte_dir_i[0] && !porte_gpio_i[0]
        |=> rdata_o[0] == $past(st_reg.pe_data[0]))
        else $error("port e other function read not stored");

    AST_PE_WRITE_NO_PIN: assert property (@(posedge clk_i)     // [R6]
        disable iff (!nrst_i)
        wr_i && addr_i == pdr_pkg::OFS_PORTE_DATA && !porte_dir_i[0]
        |=> porte_oe_n_o[0] && !porte_pin_o[0])
        else $error("port e input pin disturbed by write");

    // port f upper read bits stay clear
    AST_PF_UPPER_ZERO: assert property (@(posedge clk_i)       // [R8]
        disable iff (!nrst_i)
        rd_i && addr_i == pdr_pkg::OFS_PORTF_INPUT
        |=> rdata_o[15:PF_PINS] == '0)
        else $error("port f upper bits not zero");

    // synchronisers lag the pins by two flops once reset settled
    AST_SYNC_PORTD: assert property (@(posedge clk_i)          // [R14]
        disable iff (!nrst_i)
        $past(nrst_i) && $past(nrst_i, 2)
        |-> pd_sync == $past(portd_pin_i, pdr_pkg::SYNC_STAGES))
        else $error("port d pin not two flops behind");

    AST_SYNC_PORTF: assert property (@(posedge clk_i)          // [R14]
        disable iff (!nrst_i)
        $past(nrst_i) && $past(nrst_i, 2)
        |-> pf_sync == $past(portf_pin_i, pdr_pkg::SYNC_STAGES))
        else $error("port f pin not two flops behind");
endmodule : pdr_ports

// File: bench/pdr_pins.sv
// far-side circuit model that resolves the levels on the port pins
`timescale 1ns/1ps
module pdr_pins (
    input  wire logic [31:0] d_ext_i,   // level the far circuit presents
    input  wire logic [31:0] d_drv_i,   // device drive, port d
    input  wire logic [31:0] d_oe_n_i,  // low = device drives port d
    input  wire logic [15:0] e_ext_i,   // level the far circuit presents
    input  wire logic [15:0] e_drv_i,   // device drive, port e
    input  wire logic [15:0] e_oe_n_i,  // low = device drives port e
    output logic      [31:0] d_pin_o,   // resolved port d wire
    output logic      [15:0] e_pin_o    // resolved port e wire
);
    // ==========================================================
    // wire level: device wins where it drives, far side elsewhere
    assign d_pin_o = (~d_oe_n_i & d_drv_i) | (d_oe_n_i & d_ext_i);
    assign e_pin_o = (~e_oe_n_i & e_drv_i) | (e_oe_n_i & e_ext_i);
endmodule : pdr_pins

// File: bench/pdr_ports_bench.sv
// self-checking bench for the port data register block
`timescale 1ns/1ps
module pdr_ports_bench;
    logic        clk_i, nrst_i, wr_i, rd_i;
    logic [3:0]  addr_i;
    logic [15:0] wdata_i, rdata_o, pe_dir, pe_gpio, pe_pin, pe_out, pe_oe_n;
    logic [15:0] e_ext, se;
    logic [31:0] pd_dir, pd_gpio, pd_pin, pd_out, pd_oe_n, d_ext, sd;
    logic [7:0]  pf_adc, pf_pin;
    integer      seed, n_mismatch, n_checks, i;

    // ==========================================================
    // design, far-side circuit and clock
    pdr_ports DUT (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .portd_dir_i(pd_dir), .portd_gpio_i(pd_gpio), .porte_dir_i(pe_dir),
        .porte_gpio_i(pe_gpio), .portf_adc_i(pf_adc), .portd_pin_i(pd_pin),
        .portd_pin_o(pd_out), .portd_oe_n_o(pd_oe_n), .porte_pin_i(pe_pin),
        .porte_pin_o(pe_out), .porte_oe_n_o(pe_oe_n), .portf_pin_i(pf_pin));
    pdr_pins far (.d_ext_i(d_ext), .d_drv_i(pd_out), .d_oe_n_i(pd_oe_n),
        .e_ext_i(e_ext), .e_drv_i(pe_out), .e_oe_n_i(pe_oe_n),
        .d_pin_o(pd_pin), .e_pin_o(pe_pin));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // ==========================================================
    // compare, verdict and bus tasks
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task conclude();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        // reference storage: port f and unmapped writes vanish
        case (a)
            pdr_pkg::OFS_PORTD_UPPER: sd[31:16] = d;
            pdr_pkg::OFS_PORTD_LOWER: sd[15:0] = d;
            pdr_pkg::OFS_PORTE_DATA: se = d;
            default: ;
        endcase
    endtask : wr
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = {16'h0000, rdata_o};
    endtask : rd

    // reads every register and the pin drive against the reference
    task automatic check_all();
        logic [31:0] v, pdv;
        logic [15:0] pev;
        repeat (3) @(posedge clk_i);
        pdv = (pd_dir & sd) | (~pd_dir & d_ext);
        pev = (pe_dir & se) | (~pe_dir & e_ext);
        rd(pdr_pkg::OFS_PORTD_UPPER, v);
        chk(v, {16'h0000, pdv[31:16]});
        rd(pdr_pkg::OFS_PORTD_LOWER, v);
        chk(v, {16'h0000, pdv[15:0]});
        rd(pdr_pkg::OFS_PORTE_DATA, v);
        chk(v, {16'h0000, pev});
        rd(pdr_pkg::OFS_PORTF_INPUT, v);
        chk(v, {24'h000000, pf_pin | pf_adc});
        rd(4'(4 + ({$random(seed)} % 12)), v);
        chk(v, 32'h00000000);
        chk(pd_out, pd_dir & pd_gpio & sd);
        chk(pd_oe_n, ~(pd_dir & pd_gpio));
        chk({16'h0000, pe_out}, {16'h0000, pe_dir & pe_gpio & se});
        chk({16'h0000, pe_oe_n}, {16'h0000, ~(pe_dir & pe_gpio)});
    endtask : check_all

    // ==========================================================
    // main sequence: reset values, then random configurations
    initial begin
        seed = 68;
        n_mismatch = 0;
        n_checks = 0;
        {nrst_i, wr_i, rd_i, addr_i, wdata_i} = '0;
        {pd_gpio, pe_gpio, pf_adc, sd, se} = '0;
        // half the pins read stored bits so the reset value shows
        pd_dir = 32'h0000FFFF;
        pe_dir = 16'h00FF;
        d_ext = $random(seed);
        e_ext = 16'($random(seed));
        pf_pin = 8'($random(seed));
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        check_all();
        $display("test reset done");
        for (i = 0; i < 60; i = i + 1) begin
            @(posedge clk_i);
            pd_dir <= $random(seed);
            pd_gpio <= $random(seed);
            pe_dir <= 16'($random(seed));
            pe_gpio <= 16'($random(seed));
            pf_adc <= 8'($random(seed) & $random(seed));
            d_ext <= $random(seed);
            e_ext <= 16'($random(seed));
            pf_pin <= 8'($random(seed));
            if (i == 30) begin
                // reset in mid-run clears stored data again
                nrst_i <= 1'b0;
                @(posedge clk_i);
                nrst_i <= 1'b1;
                sd = '0;
                se = '0;
                check_all();
            end
            wr(pdr_pkg::OFS_PORTD_UPPER, 16'($random(seed)));
            wr(pdr_pkg::OFS_PORTD_LOWER, 16'($random(seed)));
            wr(pdr_pkg::OFS_PORTE_DATA, 16'($random(seed)));
            wr(pdr_pkg::OFS_PORTF_INPUT, 16'($random(seed)));
            wr(4'(4 + ({$random(seed)} % 12)), 16'($random(seed)));
            check_all();
        end
        $display("test random done");
        conclude();
    end

    // watchdog: a run past its cycle budget counts as a mismatch
    initial begin
        repeat (100000) @(posedge clk_i);
        n_mismatch = n_mismatch + 1;
        conclude();
    end
endmodule : pdr_ports_bench
